/* File: rtl/mlc_pkg.sv */
package mlc_pkg;
    // Command word layout, link table and FIFO sizes
    localparam int CW_W  = 16;
    localparam int SRC_W = 5;
    localparam int NMOD  = 32;
    localparam int FIFO_DEPTH = 4;
    // Fixed command words
    localparam logic [15:0] CMD_FILLER   = 16'h0000;
    localparam logic [15:0] CMD_VIOL     = 16'h000E;
    localparam logic [15:0] CMD_STAT_Q   = 16'h0010;
    localparam logic [15:0] CMD_TIME_Q   = 16'h0014;
    localparam logic [15:0] CMD_REMOTE   = 16'h0015;
    localparam logic [15:0] CMD_LOCAL    = 16'h0016;
    localparam logic [15:0] CMD_MODEL_Q  = 16'h0017;
    localparam logic [15:0] CMD_SERIAL_Q = 16'h0018;
    localparam logic [15:0] CMD_FW_Q     = 16'h0019;
    localparam logic [15:0] CMD_PACE_OFF = 16'h001A;
    localparam logic [15:0] CMD_PACE_ON  = 16'h001B;
    localparam logic [15:0] CMD_RPL_END  = 16'h0900;
    // High-byte opcodes
    localparam logic [7:0] OP_PLAIN_REQ = 8'h01;
    localparam logic [7:0] OP_TEARDOWN  = 8'h02;
    localparam logic [7:0] OP_GRANT     = 8'h03;
    localparam logic [7:0] OP_REFUSE    = 8'h04;
    localparam logic [7:0] OP_TD_ACK    = 8'h05;
    localparam logic [7:0] OP_STATUS    = 8'h06;
    localparam logic [7:0] OP_ADDR_SET  = 8'h07;
    localparam logic [7:0] OP_RPL_BYTE  = 8'h08;
    localparam logic [7:0] OP_INIT_TAG  = 8'h0A;
    localparam logic [7:0] OP_RESP_TAG  = 8'h0B;
    localparam logic [7:0] OP_TAG_REQ   = 8'h0E;
    // Limits and field values
    localparam logic [7:0] PLAIN_KIND_MAX = 8'h02;
    localparam logic [7:0] ADDR_LIMIT     = 8'h1F;
    localparam logic [7:0] CHR_MIN        = 8'h20;
    localparam logic [7:0] CHR_MAX        = 8'h7E;
    localparam logic [7:0] CHR_ZERO       = 8'h30;
    localparam logic [7:0] ID_MAX_LEN     = 8'h80;
    localparam logic [4:0] TIME_DIGITS    = 5'h10;
    localparam logic [4:0] DATE_DIGITS    = 5'h08;
    localparam logic [3:0] TAG_HI         = 4'h1;
    localparam logic [4:0] ADDR_RST       = 5'h1F;
    // Identity texts, values arbitrary
    localparam int ID_CHARS = 8;
    localparam logic [63:0] MODEL_TXT  = 64'h4D4F_442D_3030_3031;
    localparam logic [63:0] SERIAL_TXT = 64'h534E_3030_3030_3031;
    localparam logic [63:0] FW_TXT     = 64'h5245_562D_3031_2E30;
    localparam logic [7:0]  ID_LEN     = 8'h08;
    // Local request kinds
    localparam logic [1:0] LOC_DATA = 2'h0;
    localparam logic [1:0] LOC_LREQ = 2'h1;
    localparam logic [1:0] LOC_LBRK = 2'h2;
    localparam logic [1:0] LOC_SRQ  = 2'h3;
    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_TIME, S_ID, S_TAG} mlc_seq_e;
    typedef enum logic [1:0] {L_IDLE, L_REQ, L_UP, L_BRK} mlc_lnk_e;
endpackage

/* File: rtl/mlc_link_cmd.sv */
`timescale 1ns/1ps
`default_nettype none

module mlc_fifo #(
    parameter int W = 21,
    parameter int D = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    wire           wr = in_valid_in && in_ready_out;
    wire           rd = out_valid_out && out_ready_in;
    assign in_ready_out  = (cnt_ff != (AW+1)'(D));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out  = mem_ff[rp_ff];
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= wr ? AW'(wp_ff + 1'b1) : wp_ff;
            rp_ff  <= rd ? AW'(rp_ff + 1'b1) : rp_ff;
            cnt_ff <= (AW+1)'(cnt_ff + wr - rd);
        end
    end
    always_ff @(posedge clk_in) begin
        if (wr) begin
            mem_ff[wp_ff] <= in_data_in;
        end
    end
endmodule

module mlc_link_cmd
    import mlc_pkg::*;
(
    // Clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             RSTN_IN,
    // Received command words
    input  wire logic             CMD_VALID_IN,
    input  wire logic [CW_W-1:0]  CMD_WORD_IN,
    input  wire logic [SRC_W-1:0] CMD_SRC_IN,
    output logic                  CMD_READY_OUT,
    // Local requests
    input  wire logic             LOC_VALID_IN,
    input  wire logic [1:0]       LOC_OP_IN,
    input  wire logic [SRC_W-1:0] LOC_DST_IN,
    input  wire logic [CW_W-1:0]  LOC_ARG_IN,
    output logic                  LOC_READY_OUT,
    // Transmitted command words
    output logic                  TX_VALID_OUT,
    output logic [CW_W-1:0]       TX_WORD_OUT,
    output logic [SRC_W-1:0]      TX_DST_OUT,
    input  wire logic             TX_READY_IN,
    // Instrument state
    input  wire logic             GRANT_EN_IN,
    input  wire logic             TIME_OK_IN,
    input  wire logic             DATE_OK_IN,
    input  wire logic [63:0]      TIME_BCD_IN,
    input  wire logic [7:0]       STATUS_IN,
    input  wire logic [4:0]       ADDR_SW_IN,
    output logic                  KEY_BLANK_OUT,
    output logic [4:0]            BUS_ADDR_OUT
);
    mlc_seq_e         st_ff;
    mlc_seq_e         nxt_st;
    mlc_lnk_e         lnk_ff [NMOD];
    logic [NMOD-1:0]  rem_ff;
    logic [NMOD-1:0]  pace_ff;
    logic [NMOD-1:0]  tag_ff;
    logic [3:0]       kind_ff [NMOD];
    logic             is_cmd_ff;
    logic [1:0]       lop_ff;
    logic [CW_W-1:0]  word_ff;
    logic [SRC_W-1:0] src_ff;
    logic [63:0]      time_ff;
    logic             tok_ff;
    logic             dok_ff;
    logic [1:0]       id_sel_ff;
    logic [7:0]       idx_ff;
    logic             rdy_ff;
    logic             blank_ff;
    logic [4:0]       addr_ff;
    logic [4:0]       sw_meta_ff;
    logic [4:0]       sw_ff;
    logic             tx_valid_ff;
    logic [CW_W-1:0]  tx_word_ff;
    logic [SRC_W-1:0] tx_dst_ff;

    function automatic logic [7:0] id_char(input logic [1:0] sel, input logic [7:0] i);
        logic [63:0] t;
        logic [7:0]  c;
        t = (sel == 2'h0) ? MODEL_TXT : (sel == 2'h1) ? SERIAL_TXT : FW_TXT;
        c = t[63 - 8 * i[2:0] -: 8];
        return (c < CHR_MIN || c > CHR_MAX) ? CHR_MIN : c;
    endfunction

    // Request intake
    wire take_cmd = rdy_ff && CMD_VALID_IN;
    wire take_loc = rdy_ff && LOC_VALID_IN && !CMD_VALID_IN &&
                    !(LOC_OP_IN == LOC_DATA && pace_ff[LOC_DST_IN]);

    wire [7:0]  hi    = word_ff[15:8];
    wire [7:0]  lo    = word_ff[7:0];
    mlc_lnk_e   cur;
    assign cur = lnk_ff[src_ff];
    wire        up    = (cur == L_UP);
    wire [3:0]  kind  = word_ff[3:0];
    wire [15:0] viol  = CMD_VIOL;

    // Execute-state word and table effects
    logic            ex_push;
    logic [15:0]     ex_word;
    logic            ex_we;
    mlc_lnk_e        ex_lnk;
    logic            ex_tag;
    mlc_seq_e        ex_next;
    always_comb begin
        ex_push = 1'b0;
        ex_word = viol;
        ex_we   = 1'b0;
        ex_lnk  = cur;
        ex_tag  = tag_ff[src_ff];
        ex_next = S_IDLE;
        if (!is_cmd_ff) begin
            case (lop_ff)
                LOC_DATA: begin
                    // data only on an up link
                    ex_push = up;
                    ex_word = word_ff;
                end
                LOC_LREQ: begin
                    ex_push = 1'b1;
                    ex_word = {word_ff[8] ? OP_TAG_REQ : OP_PLAIN_REQ, 4'h0, kind};
                    ex_we   = 1'b1;
                    ex_lnk  = L_REQ;
                    ex_tag  = word_ff[8];
                end
                LOC_LBRK: begin
                    ex_push = up;
                    ex_word = {OP_TEARDOWN, 4'h0, kind_ff[src_ff]};
                    ex_we   = up;
                    ex_lnk  = L_BRK;
                end
                default: begin
                    ex_push = up;
                    ex_word = {OP_STATUS, lo};
                end
            endcase
        end else if (word_ff == CMD_TIME_Q) begin
            ex_next = S_TIME;
        end else if (word_ff == CMD_MODEL_Q || word_ff == CMD_SERIAL_Q || word_ff == CMD_FW_Q) begin
            ex_next = S_ID;
        end else if (word_ff == CMD_REMOTE || word_ff == CMD_LOCAL) begin
            ex_push = !up;
        end else if (word_ff == CMD_STAT_Q) begin
            ex_push = 1'b1;
            ex_word = {OP_STATUS, STATUS_IN};
        end else if (word_ff == CMD_VIOL || word_ff == CMD_FILLER ||
                     word_ff == CMD_PACE_OFF || word_ff == CMD_PACE_ON) begin
            ex_we  = (word_ff == CMD_VIOL);
            ex_lnk = L_IDLE;
        end else begin
            case (hi)
                OP_PLAIN_REQ, OP_TAG_REQ: begin
                    ex_push = 1'b1;
                    ex_we   = 1'b1;
                    ex_tag  = (hi == OP_TAG_REQ);
                    if (GRANT_EN_IN && (ex_tag || lo <= PLAIN_KIND_MAX)) begin
                        ex_word = {OP_GRANT, lo};
                        ex_lnk  = L_UP;
                        ex_next = ex_tag ? S_TAG : S_IDLE;
                    end else begin
                        ex_word = {OP_REFUSE, lo};
                        ex_lnk  = L_IDLE;
                    end
                end
                OP_TEARDOWN: begin
                    ex_push = (cur != L_BRK);
                    ex_word = up ? {OP_TD_ACK, lo} : viol;
                    ex_we   = 1'b1;
                    ex_lnk  = L_IDLE;
                end
                OP_GRANT, OP_REFUSE: begin
                    ex_push = (cur != L_REQ);
                    ex_we   = (cur == L_REQ);
                    ex_lnk  = (hi == OP_GRANT) ? L_UP : L_IDLE;
                    ex_next = (cur == L_REQ && hi == OP_GRANT && tag_ff[src_ff]) ? S_TAG : S_IDLE;
                end
                OP_TD_ACK: begin
                    ex_push = (cur != L_BRK);
                    ex_we   = (cur == L_BRK);
                    ex_lnk  = L_IDLE;
                end
                default: begin
                    ex_push = 1'b0;
                end
            endcase
        end
    end

    // Sequenced reply words
    wire [4:0]  tdig  = idx_ff[4:0];
    wire [3:0]  bcd   = time_ff[63 - 4 * tdig -: 4];
    wire        dzero = !dok_ff && (tdig < DATE_DIGITS);
    wire        t_end = !tok_ff || (tdig >= TIME_DIGITS);
    wire        i_end = (idx_ff >= ID_LEN) || (idx_ff >= ID_MAX_LEN);
    logic        push;
    logic [15:0] push_word;
    always_comb begin
        case (st_ff)
            S_EXEC: begin
                push      = ex_push;
                push_word = ex_word;
            end
            S_TIME: begin
                push      = 1'b1;
                push_word = t_end ? CMD_RPL_END :
                            {OP_RPL_BYTE, dzero ? CHR_ZERO : CHR_ZERO + {4'h0, bcd}};
            end
            S_ID: begin
                push      = 1'b1;
                push_word = i_end ? CMD_RPL_END : {OP_RPL_BYTE, id_char(id_sel_ff, idx_ff)};
            end
            S_TAG: begin
                push      = 1'b1;
                push_word = {is_cmd_ff && hi == OP_GRANT ? OP_INIT_TAG : OP_RESP_TAG,
                             TAG_HI, kind};
            end
            default: begin
                push      = 1'b0;
                push_word = CMD_FILLER;
            end
        endcase
    end

    wire f_in_rdy;
    wire f_out_v;
    wire [CW_W+SRC_W-1:0] f_out;
    wire go = !push || f_in_rdy;
    wire f_pop = f_out_v && (!tx_valid_ff || TX_READY_IN);

    mlc_fifo #(.W(CW_W + SRC_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_in        (CLK_IN),
        .rstn_in       (RSTN_IN),
        .in_valid_in   (push),
        .in_data_in    ({push_word, src_ff}),
        .in_ready_out  (f_in_rdy),
        .out_valid_out (f_out_v),
        .out_data_out  (f_out),
        .out_ready_in  (f_pop)
    );

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            S_IDLE: nxt_st = (take_cmd || take_loc) ? S_EXEC : S_IDLE;
            S_EXEC: nxt_st = go ? ex_next : S_EXEC;
            S_TIME: nxt_st = (go && t_end) ? S_IDLE : S_TIME;
            S_ID:   nxt_st = (go && i_end) ? S_IDLE : S_ID;
            S_TAG:  nxt_st = go ? S_IDLE : S_TAG;
            default: nxt_st = S_IDLE;
        endcase
    end

    wire [7:0] nxt_idx = (st_ff == S_EXEC) ? 8'h00 : (go ? 8'(idx_ff + 1'b1) : idx_ff);

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_ff <= S_IDLE;
            rdy_ff <= 1'b0;
            idx_ff <= 8'h00;
            sw_meta_ff <= 5'h00;
            sw_ff <= 5'h00;
        end else begin
            st_ff <= nxt_st;
            rdy_ff <= (nxt_st == S_IDLE);
            idx_ff <= nxt_idx;
            sw_meta_ff <= ADDR_SW_IN;
            sw_ff <= sw_meta_ff;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            is_cmd_ff <= 1'b0;
            lop_ff <= LOC_DATA;
            word_ff <= CMD_FILLER;
            src_ff <= '0;
            time_ff <= '0;
            tok_ff <= 1'b0;
            dok_ff <= 1'b0;
            id_sel_ff <= 2'h0;
        end else if (take_cmd || take_loc) begin
            is_cmd_ff <= take_cmd;
            lop_ff <= LOC_OP_IN;
            word_ff <= take_cmd ? CMD_WORD_IN : LOC_ARG_IN;
            src_ff <= take_cmd ? CMD_SRC_IN : LOC_DST_IN;
            time_ff <= TIME_BCD_IN;
            tok_ff <= TIME_OK_IN;
            dok_ff <= DATE_OK_IN;
            id_sel_ff <= CMD_WORD_IN[1:0] - 2'h3;
        end
    end

    wire exec_go = (st_ff == S_EXEC) && go;
    wire cmd_go  = exec_go && is_cmd_ff;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < NMOD; i++) begin
                lnk_ff[i] <= L_IDLE;
                kind_ff[i] <= 4'h0;
            end
            tag_ff <= '0;
        end else if (exec_go && ex_we) begin
            lnk_ff[src_ff] <= ex_lnk;
            kind_ff[src_ff] <= (ex_lnk == L_BRK) ? kind_ff[src_ff] : kind;
            tag_ff[src_ff] <= ex_tag;
        end
    end

    wire [NMOD-1:0] sel = NMOD'(1) << src_ff;
    wire clr_all = exec_go && ex_we && ex_lnk == L_IDLE;
    wire [NMOD-1:0] nxt_rem = clr_all ? rem_ff & ~sel :
        (cmd_go && up && word_ff == CMD_REMOTE) ? rem_ff | sel :
        (cmd_go && up && word_ff == CMD_LOCAL) ? rem_ff & ~sel : rem_ff;
    wire [NMOD-1:0] nxt_pace = clr_all ? pace_ff & ~sel :
        (cmd_go && up && tag_ff[src_ff] && word_ff == CMD_PACE_OFF) ? pace_ff | sel :
        (cmd_go && word_ff == CMD_PACE_ON) ? pace_ff & ~sel : pace_ff;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rem_ff <= '0;
            pace_ff <= '0;
            blank_ff <= 1'b0;
        end else begin
            rem_ff <= nxt_rem;
            pace_ff <= nxt_pace;
            blank_ff <= |nxt_rem;
        end
    end

    wire addr_cmd = cmd_go && hi == OP_ADDR_SET;
    wire [4:0] nxt_addr = !addr_cmd ? addr_ff : (lo >= ADDR_LIMIT) ? sw_ff : lo[4:0];

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            addr_ff <= ADDR_RST;
            tx_valid_ff <= 1'b0;
            tx_word_ff <= CMD_FILLER;
            tx_dst_ff <= '0;
        end else begin
            addr_ff <= nxt_addr;
            tx_valid_ff <= f_pop || (tx_valid_ff && !TX_READY_IN);
            tx_word_ff <= f_pop ? f_out[CW_W+SRC_W-1:SRC_W] : tx_word_ff;
            tx_dst_ff <= f_pop ? f_out[SRC_W-1:0] : tx_dst_ff;
        end
    end

    assign CMD_READY_OUT = rdy_ff;
    assign LOC_READY_OUT = rdy_ff;
    assign TX_VALID_OUT  = tx_valid_ff;
    assign TX_WORD_OUT   = tx_word_ff;
    assign TX_DST_OUT    = tx_dst_ff;
    assign KEY_BLANK_OUT = blank_ff;
    assign BUS_ADDR_OUT  = addr_ff;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence time_push_s;
        st_ff == S_TIME && push;
    endsequence

    time_inval_a: assert property (time_push_s and !tok_ff |-> push_word == CMD_RPL_END)
        else $error("time reply without terminator only");
    date_zero_a: assert property (time_push_s and tok_ff && !dok_ff && tdig < DATE_DIGITS
        |-> push_word == {OP_RPL_BYTE, CHR_ZERO}) else $error("date digit not zero");
    id_range_a: assert property (st_ff == S_ID && push && push_word[15:8] == OP_RPL_BYTE
        |-> push_word[7:0] >= CHR_MIN && push_word[7:0] <= CHR_MAX) else $error("bad char");
    id_len_a: assert property (st_ff == S_ID |-> idx_ff <= ID_MAX_LEN)
        else $error("identity reply too long");
    pace_hold_a: assert property (take_loc && LOC_OP_IN == LOC_DATA |-> !pace_ff[LOC_DST_IN])
        else $error("data taken for paced link");
    remote_blank_a: assert property (cmd_go && up && word_ff == CMD_REMOTE
        |=> ##1 KEY_BLANK_OUT) else $error("keys not blanked");
    td_ack_a: assert property (st_ff == S_EXEC && is_cmd_ff && hi == OP_TEARDOWN && up
        |-> push && push_word == {OP_TD_ACK, lo}) else $error("teardown not acknowledged");
    addr_set_a: assert property (addr_cmd && lo < ADDR_LIMIT |=> BUS_ADDR_OUT == $past(lo[4:0]))
        else $error("address not adopted");
    viol_clear_a: assert property (cmd_go && word_ff == CMD_VIOL
        |=> lnk_ff[$past(src_ff)] == L_IDLE) else $error("links not reset");
endmodule

`default_nettype wire

/* File: dv/mlc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module mlc_peer (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // Words from the block
    input  wire logic        valid_in,
    input  wire logic [15:0] word_in,
    input  wire logic [4:0]  dst_in,
    output logic             ready_out,
    // Pace control
    input  wire logic        stall_in,
    input  wire logic        fast_in
);
    logic [20:0] got[$];
    logic        ph_ff;
    assign ready_out = !stall_in && (fast_in || ph_ff);
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph_ff <= 1'h0;
        end else begin
            ph_ff <= !ph_ff;
            if (valid_in && ready_out) begin
                got.push_back({dst_in, word_in});
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mlc_pkg::*;
;
    typedef struct packed {logic [15:0] c; logic [15:0] r; logic n; logic k;} mlc_row_s;
    logic clk, rstn, cv, lv, ge, tok, dok, stall, fast, crdy, lrdy, txv, kb, txr;
    logic [15:0] cw, la, txw;
    logic [4:0]  cs, ld, sw, txd, ba;
    logic [1:0]  lo;
    logic [63:0] tb;
    logic [7:0]  st;
    logic [7:0]  av [4] = '{8'h05, 8'h1E, 8'h1F, 8'hFF};
    logic [63:0] txt;
    int errors, comparisons, cyc;
    mlc_row_s rows [17] = '{
        '{16'h0010, 16'h06A5, 1'h1, 1'h0},
        '{16'h0015, 16'h000E, 1'h1, 1'h0},
        '{16'h0016, 16'h000E, 1'h1, 1'h0},
        '{16'h0202, 16'h000E, 1'h1, 1'h0},
        '{16'h0302, 16'h000E, 1'h1, 1'h0},
        '{16'h0402, 16'h000E, 1'h1, 1'h0},
        '{16'h0502, 16'h000E, 1'h1, 1'h0},
        '{16'h0000, 16'h0000, 1'h0, 1'h0},
        '{16'h0102, 16'h0302, 1'h1, 1'h0},
        '{16'h0015, 16'h0000, 1'h0, 1'h1},
        '{16'h0016, 16'h0000, 1'h0, 1'h0},
        '{16'h0015, 16'h0000, 1'h0, 1'h1},
        '{16'h000E, 16'h0000, 1'h0, 1'h0},
        '{16'h0015, 16'h000E, 1'h1, 1'h0},
        '{16'h0102, 16'h0302, 1'h1, 1'h0},
        '{16'h0202, 16'h0502, 1'h1, 1'h0},
        '{16'h0015, 16'h000E, 1'h1, 1'h0}};
    mlc_link_cmd u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .CMD_VALID_IN(cv), .CMD_WORD_IN(cw),
        .CMD_SRC_IN(cs), .CMD_READY_OUT(crdy), .LOC_VALID_IN(lv), .LOC_OP_IN(lo),
        .LOC_DST_IN(ld), .LOC_ARG_IN(la), .LOC_READY_OUT(lrdy), .TX_VALID_OUT(txv),
        .TX_WORD_OUT(txw), .TX_DST_OUT(txd), .TX_READY_IN(txr), .GRANT_EN_IN(ge),
        .TIME_OK_IN(tok), .DATE_OK_IN(dok), .TIME_BCD_IN(tb), .STATUS_IN(st),
        .ADDR_SW_IN(sw), .KEY_BLANK_OUT(kb), .BUS_ADDR_OUT(ba));
    mlc_peer u_peer (.clk_in(clk), .rstn_in(rstn), .valid_in(txv), .word_in(txw),
        .dst_in(txd), .ready_out(txr), .stall_in(stall), .fast_in(fast));
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [20:0] e, input logic [20:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pw(input logic [20:0] e);
        logic [20:0] g;
        g = 'x;
        if (u_peer.got.size() > 0) g = u_peer.got.pop_front();
        cmp("tx_word", e, g);
    endtask
    task automatic none();
        cmp("tx_count", 21'h0, 21'(u_peer.got.size()));
    endtask
    task automatic settle();
        int q;
        int n;
        q = 0;
        n = 0;
        while (q < 4 && n < 400) begin
            @(posedge clk);
            #1;
            q = (crdy && !txv) ? q + 1 : 0;
            n++;
        end
    endtask
    task automatic cmd(input logic [15:0] w, input logic [4:0] s);
        cw = w;
        cs = s;
        cv = 1'h1;
        while (!crdy) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cv = 1'h0;
        settle();
    endtask
    task automatic loc(input logic [1:0] o, input logic [4:0] d, input logic [15:0] a);
        lo = o;
        ld = d;
        la = a;
        lv = 1'h1;
        while (!lrdy) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        lv = 1'h0;
        settle();
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        {cv, lv, cw, cs, lo, ld, la, stall, fast, rstn} = '0;
        {ge, tok, dok} = 3'h7;
        tb = 64'h2024_0315_1230_4599;
        st = 8'hA5;
        sw = 5'h0A;
        repeat (10) @(posedge clk);
        #1;
        cmp("rst_addr", 21'h1F, {16'h0, ba});
        cmp("rst_tx", 21'h0, {20'h0, txv});
        rstn = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 17; i++) begin
            cmd(rows[i].c, 5'h03);
            if (rows[i].n) pw({5'h03, rows[i].r});
            none();
            cmp("key_blank", {20'h0, rows[i].k}, {20'h0, kb});
        end
        dok = 1'h0;
        stall = 1'h1;
        cmd(CMD_TIME_Q, 5'h03);
        repeat (40) @(posedge clk);
        #1;
        stall = 1'h0;
        settle();
        for (int i = 0; i < 16; i++) begin
            pw({5'h03, OP_RPL_BYTE, CHR_ZERO | (i < 8 ? 8'h0 : {4'h0, tb[63-4*i -: 4]})});
        end
        pw({5'h03, CMD_RPL_END});
        tok = 1'h0;
        cmd(CMD_TIME_Q, 5'h03);
        pw({5'h03, CMD_RPL_END});
        none();
        fast = 1'h1;
        for (int k = 0; k < 3; k++) begin
            txt = (k == 0) ? MODEL_TXT : (k == 1) ? SERIAL_TXT : FW_TXT;
            cmd(CMD_MODEL_Q + 16'(k), 5'h03);
            for (int i = 0; i < ID_CHARS; i++) begin
                cmp("id_chr", 21'h1, {20'h0, u_peer.got[0][7:0] >= CHR_MIN
                    && u_peer.got[0][7:0] <= CHR_MAX});
                pw({5'h03, OP_RPL_BYTE, txt[63-8*i -: 8]});
            end
            pw({5'h03, CMD_RPL_END});
        end
        for (int i = 0; i < 4; i++) begin
            cmd({OP_ADDR_SET, av[i]}, 5'h03);
            cmp("bus_addr", {16'h0, av[i] < ADDR_LIMIT ? av[i][4:0] : sw}, {16'h0, ba});
        end
        cmd(16'h0102, 5'h03);
        pw({5'h03, 16'h0302});
        loc(LOC_SRQ, 5'h03, 16'h005A);
        pw({5'h03, OP_STATUS, 8'h5A});
        ge = 1'h0;
        cmd(16'h0101, 5'h03);
        pw({5'h03, 16'h0401});
        ge = 1'h1;
        loc(LOC_LREQ, 5'h04, 16'h0001);
        pw({5'h04, 16'h0101});
        cmd(16'h0401, 5'h04);
        loc(LOC_DATA, 5'h04, 16'h1234);
        none();
        loc(LOC_LREQ, 5'h06, 16'h0102);
        pw({5'h06, 16'h0E02});
        cmd(16'h0302, 5'h06);
        pw({5'h06, 16'h0A12});
        cmd(CMD_PACE_OFF, 5'h06);
        cmd(CMD_FILLER, 5'h06);
        cmd(CMD_FILLER, 5'h06);
        loc(LOC_DATA, 5'h06, 16'h5555);
        none();
        cmd(CMD_PACE_ON, 5'h06);
        loc(LOC_DATA, 5'h06, 16'h5555);
        pw({5'h06, 16'h5555});
        loc(LOC_LBRK, 5'h06, 16'h0002);
        pw({5'h06, 16'h0202});
        cmd(16'h0202, 5'h06);
        none();
        loc(LOC_DATA, 5'h06, 16'h7777);
        none();
        tally_and_finish();
    end
endmodule
`default_nettype wire
